// ==== include/svs_pkg.sv ====
// ----------------------------------------------------------------
// Constants of the sequence voltage supervision stage
// ----------------------------------------------------------------
package svs_pkg;
    // Register byte offsets
    localparam logic [7:0] SVS_CTRL_OFS = 8'h00;
    localparam logic [7:0] SVS_THR_OFS = 8'h04;
    localparam logic [7:0] SVS_RATIO_OFS = 8'h08;
    localparam logic [7:0] SVS_DELAY_OFS = 8'h0c;
    localparam logic [7:0] SVS_STAT_OFS = 8'h10;

    // Control field positions
    localparam int SVS_MODE_LSB = 0;
    localparam int SVS_MODE_MSB = 1;
    localparam int SVS_BLK_PERMIT_BIT = 2;
    localparam int SVS_TC_PERMIT_BIT = 3;
    localparam int SVS_PERM_TC_BIT = 4;
    localparam int SVS_RATIO_EN_BIT = 5;
    localparam int SVS_ASG_LSB = 6;
    localparam int SVS_ASG_MSB = 8;
    localparam int SVS_TC_ASG_BIT = 9;

    // Supervision selection
    typedef enum logic [1:0] {
        SVS_UNUSED = 2'h0,
        SVS_POS_OVER = 2'h1,
        SVS_POS_UNDER = 2'h2,
        SVS_NEG_OVER = 2'h3
    } svs_mode_t;

    // Threshold in hundredths of nominal voltage
    localparam logic [7:0] SVS_THR_MIN = 8'h01;
    localparam logic [7:0] SVS_THR_MAX = 8'h96;
    localparam logic [7:0] SVS_THR_RST = 8'h64;
    // Ratio pickup in percent
    localparam logic [5:0] SVS_RATIO_MIN = 6'h02;
    localparam logic [5:0] SVS_RATIO_MAX = 6'h28;
    localparam logic [5:0] SVS_RATIO_RST = 6'h14;
    // Delay in 10 ms steps, 0.00 to 300.00 s
    localparam logic [14:0] SVS_DELAY_MAX = 15'h7530;
    localparam logic [14:0] SVS_DELAY_RST = 15'h0000;

    // Timing: one delay step and the clock period
    localparam int SVS_STEP_NS = 10_000_000;
    localparam int SVS_CLK_NS = 4;
    localparam int SVS_STEP_CYC = SVS_STEP_NS / SVS_CLK_NS;

    // Scaling: 100 squared, three squared, sin(120 deg) in Q14
    localparam longint SVS_PCT_SQ = 64'h2710;
    localparam longint SVS_THIRD_SQ = 64'h9;
    localparam logic signed [31:0] SVS_SIN120_Q14 = 32'sh0000_376d;
    localparam int SVS_Q = 14;
endpackage

// ==== verilog/svs_stage.sv ====
// Function
// - Selection: unused, pos over, pos under, neg over
// - Sequence quantity derived from three phase phasors
// - Alarm as soon as threshold is passed
// - Trip after continuous pickup for whole delay
// - Negative over may AND with ratio criterion
// - Ratio acts only when enabled and validly set
// - Assigned, permitted external input blocks whole stage
// - Permitted external input blocks trip command only
// - Threshold 0.01 to 1.50 nominal, default 1.00
// - Ratio pickup 2 to 40 percent, default 20
// - Permanent trip command block, default off
// - Permissions act only for assigned inputs
`timescale 1ns/100ps
`default_nettype none
module svs_stage #(
    parameter int STEP_CYC = svs_pkg::SVS_STEP_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Phase voltage phasors, Q format, nominal = vn_code
    input wire logic meas_valid,
    input wire logic signed [15:0] va_re,
    input wire logic signed [15:0] va_im,
    input wire logic signed [15:0] vb_re,
    input wire logic signed [15:0] vb_im,
    input wire logic signed [15:0] vc_re,
    input wire logic signed [15:0] vc_im,
    input wire logic [15:0] vn_code,
    // External blocking pins
    input wire logic ext_block_in_a,
    input wire logic ext_block_in_b,
    input wire logic ext_block_in_c,
    input wire logic ext_trip_cmd_block_in,
    // Stage outputs
    output logic alarm,
    output logic trip,
    output logic trip_cmd,
    output logic blocked
);
    import svs_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Rotate a phasor by +120 (dir=1) or -120 degrees
    function automatic logic signed [63:0] rot(
        input logic signed [31:0] re,
        input logic signed [31:0] im,
        input logic dir
    );
        logic signed [31:0] kre;
        logic signed [31:0] kim;
        logic signed [31:0] ore;
        logic signed [31:0] oim;
        kre = 32'((64'(re) * 64'(SVS_SIN120_Q14)) >>> SVS_Q);
        kim = 32'((64'(im) * 64'(SVS_SIN120_Q14)) >>> SVS_Q);
        ore = dir ? (-(re >>> 1) - kim) : (-(re >>> 1) + kim);
        oim = dir ? (kre - (im >>> 1)) : (-kre - (im >>> 1));
        return {ore, oim};
    endfunction

    // Squared magnitude of a phasor
    function automatic logic [63:0] mag_sq(
        input logic signed [31:0] re,
        input logic signed [31:0] im
    );
        return 64'(64'(re) * 64'(re)) + 64'(64'(im) * 64'(im));
    endfunction

    // ------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------
    svs_mode_t mode_r;          // Planning selection
    logic blk_permit_r;         // Whole stage block allowed
    logic tc_permit_r;          // Trip command block allowed
    logic perm_trip_cmd_block;  // Permanent trip command block
    logic ratio_en_r;           // Ratio criterion in use
    logic [2:0] asg_r;          // Inputs a..c assigned
    logic tc_asg_r;             // Trip command input assigned
    logic [7:0] thr_r;          // Threshold, hundredths of nominal
    logic [5:0] ratio_r;        // Ratio pickup, percent
    logic [14:0] delay_r;       // Delay, 10 ms steps
    logic [7:0] thr_nxt;
    logic [14:0] delay_nxt;

    // Clamp threshold and delay into their legal ranges
    always_comb begin
        thr_nxt = reg_wdata[7:0];
        if (reg_wdata[7:0] < SVS_THR_MIN) begin
            thr_nxt = SVS_THR_MIN;
        end else if (reg_wdata[7:0] > SVS_THR_MAX) begin
            thr_nxt = SVS_THR_MAX;
        end
        delay_nxt = reg_wdata[14:0];
        if (reg_wdata[14:0] > SVS_DELAY_MAX) begin
            delay_nxt = SVS_DELAY_MAX;
        end
    end

    // Register writes
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mode_r <= SVS_UNUSED;
            blk_permit_r <= 1'b0;
            tc_permit_r <= 1'b0;
            perm_trip_cmd_block <= 1'b0;
            ratio_en_r <= 1'b0;
            asg_r <= 3'h0;
            tc_asg_r <= 1'b0;
            thr_r <= SVS_THR_RST;
            ratio_r <= SVS_RATIO_RST;
            delay_r <= SVS_DELAY_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                SVS_CTRL_OFS: begin
                    mode_r <= svs_mode_t'(
                        reg_wdata[SVS_MODE_MSB:SVS_MODE_LSB]);
                    blk_permit_r <= reg_wdata[SVS_BLK_PERMIT_BIT];
                    tc_permit_r <= reg_wdata[SVS_TC_PERMIT_BIT];
                    perm_trip_cmd_block <= reg_wdata[SVS_PERM_TC_BIT];
                    ratio_en_r <= reg_wdata[SVS_RATIO_EN_BIT];
                    asg_r <= reg_wdata[SVS_ASG_MSB:SVS_ASG_LSB];
                    tc_asg_r <= reg_wdata[SVS_TC_ASG_BIT];
                end
                SVS_THR_OFS: begin
                    thr_r <= thr_nxt;
                end
                SVS_RATIO_OFS: begin
                    // Stored as written; out of range disables it
                    ratio_r <= reg_wdata[5:0];
                end
                SVS_DELAY_OFS: begin
                    delay_r <= delay_nxt;
                end
                default: begin
                    // Read-only or unmapped: write ignored
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_meta_r;  // First stage, read only by second
    logic [3:0] pin_sync_r;  // Safe copies: c, b, a, trip cmd

    // Two flops per external blocking pin
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_meta_r <= 4'h0;
            pin_sync_r <= 4'h0;
        end else begin
            pin_meta_r <= {ext_block_in_c, ext_block_in_b,
                ext_block_in_a, ext_trip_cmd_block_in};
            pin_sync_r <= pin_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Sequence components
    // ------------------------------------------------------------
    logic [63:0] v1_sq_r;  // |3*V1| squared
    logic [63:0] v2_sq_r;  // |3*V2| squared
    logic signed [63:0] b_p;
    logic signed [63:0] c_p;
    logic signed [63:0] b_m;
    logic signed [63:0] c_m;

    // a*Vb, a^2*Vc feed V1; a^2*Vb, a*Vc feed V2
    always_comb begin
        b_p = rot(32'(vb_re), 32'(vb_im), 1'b1);
        c_p = rot(32'(vc_re), 32'(vc_im), 1'b0);
        b_m = rot(32'(vb_re), 32'(vb_im), 1'b0);
        c_m = rot(32'(vc_re), 32'(vc_im), 1'b1);
    end

    // Capture magnitudes on each fresh measurement
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            v1_sq_r <= 64'h0;
            v2_sq_r <= 64'h0;
        end else if (meas_valid) begin
            v1_sq_r <= mag_sq(32'(va_re) + b_p[63:32] + c_p[63:32],
                32'(va_im) + b_p[31:0] + c_p[31:0]);
            v2_sq_r <= mag_sq(32'(va_re) + b_m[63:32] + c_m[63:32],
                32'(va_im) + b_m[31:0] + c_m[31:0]);
        end
    end

    // ------------------------------------------------------------
    // Pickup decision
    // ------------------------------------------------------------
    // Squares avoid a root; the factor 3 folds into the reference
    logic [63:0] ref_sq;
    logic [63:0] v1_scaled;
    logic [63:0] v2_scaled;
    logic ratio_valid;
    logic ratio_ok;
    logic pickup;

    always_comb begin
        ref_sq = SVS_THIRD_SQ * 64'(thr_r) * 64'(thr_r)
            * 64'(vn_code) * 64'(vn_code);
        v1_scaled = SVS_PCT_SQ * v1_sq_r;
        v2_scaled = SVS_PCT_SQ * v2_sq_r;
        ratio_valid = ratio_en_r && (ratio_r >= SVS_RATIO_MIN)
            && (ratio_r <= SVS_RATIO_MAX);
        // 100*UNBALANCE_RATIO_CRITERION > p, as squares
        ratio_ok = v2_scaled
            > 64'(ratio_r) * 64'(ratio_r) * v1_sq_r;
        unique case (mode_r)
            SVS_POS_OVER: pickup = v1_scaled > ref_sq;
            SVS_POS_UNDER: pickup = v1_scaled < ref_sq;
            SVS_NEG_OVER: begin
                // Missing V1 passes the ratio check, so V2 above threshold alone can trip
                pickup = (v2_scaled > ref_sq)
                    && (!ratio_valid || ratio_ok);
            end
            default: pickup = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Blocking
    // ------------------------------------------------------------
    logic stage_blk;
    logic tc_blk;

    always_comb begin
        stage_blk = (mode_r == SVS_UNUSED) || (blk_permit_r
            && |(asg_r & pin_sync_r[3:1]));
        tc_blk = perm_trip_cmd_block || (tc_permit_r && tc_asg_r
            && pin_sync_r[0]);
    end

    // ------------------------------------------------------------
    // Delay state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SVS_ST_IDLE = 3'b001,
        SVS_ST_TIMING = 3'b010,
        SVS_ST_TRIPPED = 3'b100
    } svs_state_t;

    svs_state_t state_r;
    logic [31:0] pre_r;    // Cycles within one 10 ms step
    logic [14:0] steps_r;  // Whole steps elapsed
    logic step_done;

    assign step_done = (pre_r == 32'(STEP_CYC - 1));

    // Pickup holds, timer runs; any gap restarts it
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_r <= SVS_ST_IDLE;
            pre_r <= 32'h0;
            steps_r <= 15'h0;
        end else if (stage_blk || !pickup) begin
            state_r <= SVS_ST_IDLE;
            pre_r <= 32'h0;
            steps_r <= 15'h0;
        end else begin
            unique case (state_r)
                SVS_ST_IDLE: begin
                    state_r <= SVS_ST_TIMING;
                    pre_r <= 32'h0;
                    steps_r <= 15'h0;
                end
                SVS_ST_TIMING: begin
                    if (steps_r >= delay_r) begin
                        state_r <= SVS_ST_TRIPPED;
                    end else if (step_done) begin
                        pre_r <= 32'h0;
                        steps_r <= steps_r + 15'h1;
                    end else begin
                        pre_r <= pre_r + 32'h1;
                    end
                end
                SVS_ST_TRIPPED: begin
                    state_r <= SVS_ST_TRIPPED;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Registered stage outputs; blocked stage shows only blocked
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            alarm <= 1'b0;
            trip <= 1'b0;
            trip_cmd <= 1'b0;
            blocked <= 1'b0;
        end else begin
            alarm <= pickup && !stage_blk;
            trip <= (state_r == SVS_ST_TRIPPED) && pickup
                && !stage_blk;
            trip_cmd <= (state_r == SVS_ST_TRIPPED) && pickup
                && !stage_blk && !tc_blk;
            blocked <= stage_blk;
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                SVS_CTRL_OFS: reg_rdata <= 32'({tc_asg_r, asg_r,
                    ratio_en_r, perm_trip_cmd_block, tc_permit_r,
                    blk_permit_r, mode_r});
                SVS_THR_OFS: reg_rdata <= 32'(thr_r);
                SVS_RATIO_OFS: reg_rdata <= 32'(ratio_r);
                SVS_DELAY_OFS: reg_rdata <= 32'(delay_r);
                SVS_STAT_OFS: reg_rdata <= 32'({pin_sync_r, tc_blk,
                    blocked, trip_cmd, trip, alarm});
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end
endmodule
`default_nettype wire

// ==== verif/svs_meas_src.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Three-phase phasor source
// ----------------------------------------
module svs_meas_src (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Wanted sequence magnitudes
    input wire logic [15:0] pos_mag,
    input wire logic [15:0] neg_mag,
    // Phasors to the stage
    output logic meas_valid,
    output logic signed [15:0] va_re,
    output logic signed [15:0] va_im,
    output logic signed [15:0] vb_re,
    output logic signed [15:0] vb_im,
    output logic signed [15:0] vc_re,
    output logic signed [15:0] vc_im
);
    logic [1:0] tick_r; // Frame counter, one sample in four
    logic [15:0] mk; // Garbles phasors outside the sample
    int p, n;
    real s;
    // Sample pulse every fourth cycle
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tick_r <= 2'h0;
        end else begin
            tick_r <= tick_r + 2'h1;
        end
    end
    assign meas_valid = (tick_r == 2'h3);
    // Phases built from wanted sequences; inverse between samples
    always @(posedge mclk) begin
        p = int'(pos_mag);
        n = int'(neg_mag);
        s = 0.8660254;
        mk = (tick_r == 2'h2) ? 16'h0000 : 16'hffff;
        va_re <= 16'(p + n) ^ mk;
        va_im <= mk;
        vb_re <= 16'(-(p + n) / 2) ^ mk;
        vb_im <= 16'($rtoi((n - p) * s)) ^ mk;
        vc_re <= 16'(-(p + n) / 2) ^ mk;
        vc_im <= 16'($rtoi((p - n) * s)) ^ mk;
    end
endmodule
`default_nettype wire

// ==== verif/svs_stage_props.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Output relation checker
// ----------------------------------------
module svs_stage_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Stage outputs
    input wire logic alarm,
    input wire logic trip,
    input wire logic trip_cmd,
    input wire logic blocked
);
    import svs_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [1:0] sel_r; // Shadow of the selection field
    // Follow selection writes, as the stage does
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sel_r <= 2'h0;
        end else if (reg_wr && reg_addr == SVS_CTRL_OFS) begin
            sel_r <= reg_wdata[1:0];
        end
    end
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read");
    unmapped_read_a: assert property ($past(reg_rd) &&
        $past(reg_addr) > SVS_STAT_OFS |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    status_mirror_a: assert property (
        reg_rd && reg_addr == SVS_STAT_OFS |=>
        reg_rdata[3:0] == $past({blocked, trip_cmd, trip, alarm}))
        else $error("status differs from outputs");
    cmd_needs_trip_a: assert property (trip_cmd |-> trip)
        else $error("trip command without trip");
    trip_after_alarm_a: assert property (
        $rose(trip) |-> $past(alarm) && $past(alarm, 2))
        else $error("trip without alarm lead");
    trip_drop_a: assert property (!alarm [*2] |-> !trip)
        else $error("trip held without pickup");
    blocked_quiet_a: assert property (
        blocked && $past(blocked) |-> !alarm && !trip && !trip_cmd)
        else $error("output active while blocked");
    unused_quiet_a: assert property (
        sel_r == SVS_UNUSED && $past(sel_r) == SVS_UNUSED |-> !alarm && !trip)
        else $error("output active while unused");
endmodule
bind svs_stage svs_stage_props svs_stage_props_inst (.mclk(mclk),
    .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .alarm(alarm), .trip(trip), .trip_cmd(trip_cmd), .blocked(blocked));
`default_nettype wire

// ==== verif/tb_svs_stage.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_svs_stage;
    import svs_pkg::*;
    localparam int VN = 1000; // Nominal code
    logic mclk, rstn, reg_wr, reg_rd, meas_valid, tc_pin;
    logic alarm, trip, trip_cmd, blocked;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [15:0] pos_mag, neg_mag;
    logic signed [15:0] va_re, va_im, vb_re, vb_im, vc_re, vc_im;
    logic [2:0] ext; // External stage block pins
    int err_total, n_tests, cyc, k;
    int vn; // Nominal code driven to the stage
    // ----------------------------------------
    // Design and phasor source
    // ----------------------------------------
    svs_stage #(.STEP_CYC(4)) svs_stage_inst (.mclk(mclk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
        .va_re(va_re), .va_im(va_im), .vb_re(vb_re), .vb_im(vb_im),
        .vc_re(vc_re), .vc_im(vc_im), .vn_code(16'(vn)),
        .ext_block_in_a(ext[0]), .ext_block_in_b(ext[1]),
        .ext_block_in_c(ext[2]), .ext_trip_cmd_block_in(tc_pin),
        .alarm(alarm), .trip(trip), .trip_cmd(trip_cmd), .blocked(blocked));
    svs_meas_src svs_meas_src_inst (.mclk(mclk), .rstn(rstn),
        .pos_mag(pos_mag), .neg_mag(neg_mag), .meas_valid(meas_valid),
        .va_re(va_re), .va_im(va_im), .vb_re(vb_re), .vb_im(vb_im),
        .vc_re(vc_re), .vc_im(vc_im));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Expected pickup; ratio counts only when enabled and in range
    function automatic logic exp_alarm(input logic [1:0] m, input int p,
        input int n, input int thr, input logic ren, input int rp);
        int q;
        logic r;
        q = (m == SVS_NEG_OVER) ? n : p;
        r = !(ren && rp >= 2 && rp <= 40) || (n * 100 > rp * p);
        exp_alarm = (m == SVS_POS_UNDER) ? (q * 100 < thr * vn) :
            (m != SVS_UNUSED) && (q * 100 > thr * vn) &&
            (m != SVS_NEG_OVER || r);
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Settings, stimulus, settle, then judge all outputs
    task automatic run(input string nm, input logic [31:0] c, input int thr,
        input int rp, input int p, input int n, input logic blk,
        input logic tcb);
        logic ea;
        logic eb;
        logic [8:0] es;
        logic [31:0] st;
        wr(SVS_CTRL_OFS, c);
        wr(SVS_THR_OFS, 32'(thr));
        wr(SVS_RATIO_OFS, 32'(rp));
        @(posedge mclk);
        pos_mag <= 16'(p);
        neg_mag <= 16'(n);
        repeat (24) @(posedge mclk);
        #1;
        ea = !blk && exp_alarm(c[1:0], p, n, thr, c[5], rp);
        // An unused selection reports itself as blocked
        eb = blk || (c[1:0] == SVS_UNUSED);
        chk({nm, " alarm"}, alarm, ea);
        chk({nm, " trip"}, trip, ea);
        chk({nm, " cmd"}, trip_cmd, ea && !tcb);
        chk({nm, " blocked"}, blocked, eb);
        // Status word: pins c..a, trip cmd pin, cmd block, outputs
        es = {ext, tc_pin, tcb, eb, ea && !tcb, ea, ea};
        rd(SVS_STAT_OFS, st);
        chk({nm, " status"}, st, 32'(es));
        $display("test %s done", nm);
        // Leave on a rising edge so the next stimulus lands on it
        @(posedge mclk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rstn, reg_wr, reg_rd, tc_pin, ext, reg_addr} = '0;
        {reg_wdata, pos_mag, neg_mag} = '0;
        vn = VN;
        v = $urandom(32'h02d0_08ea);
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        rd(SVS_CTRL_OFS, v);
        chk("ctrl reset", v, 32'h0);
        rd(SVS_THR_OFS, v);
        chk("thr reset", v, 32'h64);
        rd(SVS_RATIO_OFS, v);
        chk("ratio reset", v, 32'h14);
        rd(SVS_DELAY_OFS, v);
        chk("delay reset", v, 32'h0);
        rd(8'h20, v);
        chk("unmapped", v, 32'h0);
        wr(SVS_THR_OFS, 32'h0000_00c8);
        rd(SVS_THR_OFS, v);
        chk("thr high clamp", v, 32'h96);
        wr(SVS_THR_OFS, 32'h0);
        rd(SVS_THR_OFS, v);
        chk("thr low clamp", v, 32'h01);
        $display("test registers done");
        for (k = 0; k < 4; k++) begin
            run("mode hi", 32'(k), 100, 20, 1200, 300, 1'b0, 1'b0);
            run("mode lo", 32'(k), 100, 20, 800, 1200, 1'b0, 1'b0);
        end
        run("ratio low", 32'h23, 10, 20, 1000, 150, 1'b0, 1'b0);
        run("ratio met", 32'h23, 10, 10, 1000, 150, 1'b0, 1'b0);
        run("ratio bad", 32'h23, 10, 50, 1000, 150, 1'b0, 1'b0);
        // One pin at a time; each pin held for an assigned and an unassigned run
        for (k = 0; k < 3; k++) begin
            ext <= 3'(1 << k);
            run("ext blk", 32'h05 | (32'h40 << k), 100, 20, 1200, 0, 1'b1,
                1'b0);
            run("no assign", 32'h05, 100, 20, 1200, 0, 1'b0, 1'b0);
        end
        ext <= 3'h0;
        tc_pin <= 1'b1;
        run("tc blk", 32'h209, 100, 20, 1200, 0, 1'b0, 1'b1);
        run("tc no asg", 32'h09, 100, 20, 1200, 0, 1'b0, 1'b0);
        tc_pin <= 1'b0;
        run("perm blk", 32'h11, 100, 20, 1200, 0, 1'b0, 1'b1);
        // Nominal code varies too, thresholds scale with it
        for (k = 0; k < 8; k++) begin
            vn <= 900 + 100 * $urandom_range(0, 2);
            run("random", 32'($urandom_range(1, 3)), 100, 20,
                600 + 700 * $urandom_range(0, 1) + $urandom_range(0, 200),
                600 + 700 * $urandom_range(0, 1) + $urandom_range(0, 200),
                1'b0, 1'b0);
        end
        vn <= VN;
        wr(SVS_DELAY_OFS, 32'h0000_7fff);
        rd(SVS_DELAY_OFS, v);
        chk("delay clamp", v, 32'h7530);
        wr(SVS_DELAY_OFS, 32'h3);
        run("delay idle", 32'h01, 100, 20, 800, 0, 1'b0, 1'b0);
        pos_mag <= 16'h04b0;
        for (k = 0; k < 40 && !alarm; k++) @(posedge mclk);
        for (k = 0; k < 40 && !trip; k++) @(posedge mclk);
        chk("delay cycles", 32'(k >= 12 && k <= 16), 32'h1);
        $display("test delay done");
        final_report();
    end
endmodule
`default_nettype wire
